// ### hdl/mic_misc_io.sv
// Miscellaneous I/O: bit-bang serial ports, general outputs, clock, reset
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module mic_misc_io
  import mic_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // First serial port pins
  input wire logic first_serial_clock_line_i,
  output logic first_serial_clock_line_o,
  output logic first_serial_clock_line_oe_o,
  input wire logic first_serial_data_line_i,
  output logic first_serial_data_line_o,
  output logic first_serial_data_line_oe_o,
  // Monitor serial port pins
  input wire logic monitor_serial_clock_line_i,
  output logic monitor_serial_clock_line_o,
  output logic monitor_serial_clock_line_oe_o,
  input wire logic monitor_serial_data_line_i,
  output logic monitor_serial_data_line_o,
  output logic monitor_serial_data_line_oe_o,
  // General outputs
  output logic general_output_pin_o,
  output logic general_output_port_pin_o,
  // PCI clock, straps, CPU reset
  input wire logic pci_clk_i,
  input wire logic [STRAP_W-1:0] strap_i,
  output logic [1:0] clock_ratio_o,
  output logic cpu_reset_n_o,
  output logic cpu_reset_delayed_n_o
);

  logic [7:0] i2c_bitbang_control_ff;
  logic [7:0] ddc_bitbang_control_ff;
  logic [7:0] seq_gpo_ff;
  logic [7:0] gop_ctrl_ff;
  logic [7:0] osel_ff;
  logic [1:0] clock_ratio_config_ff;
  logic [STRAP_W-1:0] strap_ff;
  logic strap_pend_ff;
  logic [2:0] sp1c_sync_ff;
  logic [2:0] sp1d_sync_ff;
  logic [2:0] sp2c_sync_ff;
  logic [2:0] sp2d_sync_ff;
  logic [2:0] pclk_sync_ff;
  logic sp1c_lvl_ff;
  logic sp1d_lvl_ff;
  logic sp2c_lvl_ff;
  logic sp2d_lvl_ff;
  logic pclk_lvl_ff;
  logic [7:0] pclk_cnt_ff;
  logic [7:0] pclk_period_ff;
  logic [7:0] nxt_rdata;
  logic [CPU_RST_DELAY-1:0] cpu_rst_pipe_ff;

  // Combine a control byte with sampled pin levels
  function automatic logic [7:0] sp_read(input logic [7:0] ctrl,
                                         input logic clk_lvl,
                                         input logic dat_lvl);
    logic [7:0] v;
    v = 8'h00;
    v[SP_CLK_OUT] = ctrl[SP_CLK_OUT];
    v[SP_DAT_OUT] = ctrl[SP_DAT_OUT];
    v[SP_EN] = ctrl[SP_EN];
    v[SP_CLK_IN] = clk_lvl;
    v[SP_DAT_IN] = dat_lvl;
    return v;
  endfunction

  // Software writes to the control registers
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      i2c_bitbang_control_ff <= RST_SP_CTRL;
      ddc_bitbang_control_ff <= RST_SP_CTRL;
      seq_gpo_ff <= RST_BYTE;
      gop_ctrl_ff <= RST_BYTE;
      osel_ff <= RST_BYTE;
      clock_ratio_config_ff <= RST_RATIO;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        ADDR_I2C_CTRL: i2c_bitbang_control_ff <= wdata_i;
        ADDR_DDC_CTRL: ddc_bitbang_control_ff <= wdata_i;
        ADDR_SEQ_GPO: seq_gpo_ff <= wdata_i;
        ADDR_GOP_CTRL: gop_ctrl_ff <= wdata_i;
        ADDR_OSEL: osel_ff <= wdata_i;
        ADDR_RATIO:
        begin
          if (wdata_i[1:0] != RATIO_RSVD)
            clock_ratio_config_ff <= wdata_i[1:0];
        end
        default: ;
      endcase
    end
  end

  // Three-stage synchronisers for pins and the PCI clock
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sp1c_sync_ff <= 3'h7;
      sp1d_sync_ff <= 3'h7;
      sp2c_sync_ff <= 3'h7;
      sp2d_sync_ff <= 3'h7;
      pclk_sync_ff <= 3'h0;
    end
    else
    begin
      sp1c_sync_ff <= {sp1c_sync_ff[1:0], first_serial_clock_line_i};
      sp1d_sync_ff <= {sp1d_sync_ff[1:0], first_serial_data_line_i};
      sp2c_sync_ff <= {sp2c_sync_ff[1:0], monitor_serial_clock_line_i};
      sp2d_sync_ff <= {sp2d_sync_ff[1:0], monitor_serial_data_line_i};
      pclk_sync_ff <= {pclk_sync_ff[1:0], pci_clk_i};
    end
  end

  // Accept a level once stages two and three agree
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sp1c_lvl_ff <= 1'b1;
      sp1d_lvl_ff <= 1'b1;
      sp2c_lvl_ff <= 1'b1;
      sp2d_lvl_ff <= 1'b1;
      pclk_lvl_ff <= 1'b0;
    end
    else
    begin
      if (sp1c_sync_ff[1] == sp1c_sync_ff[2])
        sp1c_lvl_ff <= sp1c_sync_ff[2];
      if (sp1d_sync_ff[1] == sp1d_sync_ff[2])
        sp1d_lvl_ff <= sp1d_sync_ff[2];
      if (sp2c_sync_ff[1] == sp2c_sync_ff[2])
        sp2c_lvl_ff <= sp2c_sync_ff[2];
      if (sp2d_sync_ff[1] == sp2d_sync_ff[2])
        sp2d_lvl_ff <= sp2d_sync_ff[2];
      if (pclk_sync_ff[1] == pclk_sync_ff[2])
        pclk_lvl_ff <= pclk_sync_ff[2];
    end
  end

  // Measure PCI clock period in host clocks for ratio checking
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pclk_cnt_ff <= 8'h00;
      pclk_period_ff <= 8'h00;
    end
    else if (pclk_sync_ff[1] == pclk_sync_ff[2] &&
             pclk_sync_ff[2] && !pclk_lvl_ff)
    begin
      pclk_period_ff <= pclk_cnt_ff + 8'h01;
      pclk_cnt_ff <= 8'h00;
    end
    else if (pclk_cnt_ff != 8'hFF)
      pclk_cnt_ff <= pclk_cnt_ff + 8'h01;
  end

  // Pin drive: enable follows SP_EN, so an enabled line is driven high and low; released when port disabled
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      first_serial_clock_line_o <= 1'b0;
      first_serial_clock_line_oe_o <= 1'b0;
      first_serial_data_line_o <= 1'b0;
      first_serial_data_line_oe_o <= 1'b0;
      monitor_serial_clock_line_o <= 1'b0;
      monitor_serial_clock_line_oe_o <= 1'b0;
      monitor_serial_data_line_o <= 1'b0;
      monitor_serial_data_line_oe_o <= 1'b0;
    end
    else
    begin
      first_serial_clock_line_o <= i2c_bitbang_control_ff[SP_CLK_OUT];
      first_serial_clock_line_oe_o <= i2c_bitbang_control_ff[SP_EN];
      first_serial_data_line_o <= i2c_bitbang_control_ff[SP_DAT_OUT];
      first_serial_data_line_oe_o <= i2c_bitbang_control_ff[SP_EN];
      monitor_serial_clock_line_o <= ddc_bitbang_control_ff[SP_CLK_OUT];
      monitor_serial_clock_line_oe_o <= ddc_bitbang_control_ff[SP_EN];
      monitor_serial_data_line_o <= ddc_bitbang_control_ff[SP_DAT_OUT];
      monitor_serial_data_line_oe_o <= ddc_bitbang_control_ff[SP_EN];
    end
  end
  // General outputs and ratio output
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      general_output_pin_o <= 1'b0;
      general_output_port_pin_o <= 1'b0;
      clock_ratio_o <= RST_RATIO;
    end
    else
    begin
      general_output_pin_o <= seq_gpo_ff[GPO_BIT];
      if (!osel_ff[OSEL_BIT])
        general_output_port_pin_o <= gop_ctrl_ff[GPO_BIT];
      clock_ratio_o <= clock_ratio_config_ff;
    end
  end
  // Strap capture on the first edge after reset release
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      strap_pend_ff <= 1'b1;
      strap_ff <= '0;
    end
    else if (strap_pend_ff)
    begin
      strap_pend_ff <= 1'b0;
      strap_ff <= strap_i;
    end
  end
  // CPU reset and its two-cycle delayed copy
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cpu_reset_n_o <= 1'b0;
      cpu_reset_delayed_n_o <= 1'b0;
      cpu_rst_pipe_ff <= '0;
    end
    else
    begin
      cpu_reset_n_o <= 1'b1;
      cpu_rst_pipe_ff <= {cpu_rst_pipe_ff[CPU_RST_DELAY-2:0], 1'b1};
      cpu_reset_delayed_n_o <= cpu_rst_pipe_ff[CPU_RST_DELAY-1];
    end
  end
  // Read mux; status bits reflect sampled pin levels
  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (addr_i)
      ADDR_I2C_CTRL: nxt_rdata = sp_read(i2c_bitbang_control_ff,
                                         sp1c_lvl_ff, sp1d_lvl_ff);
      ADDR_DDC_CTRL: nxt_rdata = sp_read(ddc_bitbang_control_ff,
                                         sp2c_lvl_ff, sp2d_lvl_ff);
      ADDR_SEQ_GPO: nxt_rdata = seq_gpo_ff;
      ADDR_GOP_CTRL: nxt_rdata = gop_ctrl_ff;
      ADDR_OSEL: nxt_rdata = osel_ff;
      ADDR_RATIO: nxt_rdata = {6'h00, clock_ratio_config_ff};
      ADDR_STRAP: nxt_rdata = strap_ff;
      ADDR_PCLK_STAT: nxt_rdata = pclk_period_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end
  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rd_i ? nxt_rdata : 8'h00;
  end
  property p_sp1_drive;
    @(posedge mclk_i) disable iff (reset_i)
    1'b1 |=> first_serial_clock_line_o == $past(i2c_bitbang_control_ff[0])
      && first_serial_data_line_o == $past(i2c_bitbang_control_ff[1]);
  endproperty
  a_sp1_drive: assert property (p_sp1_drive)
    else $error("first serial port drive mismatch");
  property p_sp1_en;
    @(posedge mclk_i) disable iff (reset_i)
    !i2c_bitbang_control_ff[4] |=> !first_serial_clock_line_oe_o
      && !first_serial_data_line_oe_o;
  endproperty
  a_sp1_en: assert property (p_sp1_en)
    else $error("first serial port driven while disabled");
  property p_sp2_drive;
    @(posedge mclk_i) disable iff (reset_i)
    ddc_bitbang_control_ff[4] |=> monitor_serial_clock_line_oe_o
      && monitor_serial_data_line_o == $past(ddc_bitbang_control_ff[1]);
  endproperty
  a_sp2_drive: assert property (p_sp2_drive)
    else $error("monitor serial port drive mismatch");
  property p_gpo;
    @(posedge mclk_i) disable iff (reset_i)
    $changed(seq_gpo_ff[0]) |=> general_output_pin_o == $past(seq_gpo_ff[0]);
  endproperty
  a_gpo: assert property (p_gpo)
    else $error("general output pin does not follow register");
  property p_gop;
    @(posedge mclk_i) disable iff (reset_i)
    !osel_ff[4] |=> general_output_port_pin_o == $past(gop_ctrl_ff[0]);
  endproperty
  a_gop: assert property (p_gop)
    else $error("output port pin does not mirror control");
  property p_ratio;
    @(posedge mclk_i) disable iff (reset_i)
    clock_ratio_config_ff != 2'h3;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("reserved clock ratio stored");
  property p_rst_delay;
    @(posedge mclk_i) disable iff (reset_i)
    $rose(cpu_reset_n_o) |-> !cpu_reset_delayed_n_o ##2
      cpu_reset_delayed_n_o;
  endproperty
  a_rst_delay: assert property (p_rst_delay)
    else $error("delayed cpu reset not two cycles late");
  property p_strap;
    @(posedge mclk_i) disable iff (reset_i)
    $fell(strap_pend_ff) |-> strap_ff == $past(strap_i);
  endproperty
  a_strap: assert property (p_strap)
    else $error("straps not captured at reset release");
endmodule

// ### hdl/mic_pkg.sv
// Constants for the miscellaneous I/O, clock ratio and reset block
package mic_pkg;
  // Register offsets (chosen, byte address = 4 * index)
  localparam logic [7:0] ADDR_I2C_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DDC_CTRL = 8'h04;
  localparam logic [7:0] ADDR_SEQ_GPO = 8'h08;
  localparam logic [7:0] ADDR_GOP_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_OSEL = 8'h10;
  localparam logic [7:0] ADDR_RATIO = 8'h14;
  localparam logic [7:0] ADDR_STRAP = 8'h18;
  localparam logic [7:0] ADDR_PCLK_STAT = 8'h1C;
  // Field positions in the serial port control registers
  localparam int SP_CLK_OUT = 0;
  localparam int SP_DAT_OUT = 1;
  localparam int SP_CLK_IN = 2;
  localparam int SP_DAT_IN = 3;
  localparam int SP_EN = 4;
  // Field positions elsewhere
  localparam int GPO_BIT = 0;
  localparam int OSEL_BIT = 4;
  // Reset values
  localparam logic [7:0] RST_SP_CTRL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_RATIO = 2'h0;
  // Clock ratio encodings
  localparam logic [1:0] RATIO_2X = 2'h0;
  localparam logic [1:0] RATIO_3X = 2'h1;
  localparam logic [1:0] RATIO_4X = 2'h2;
  localparam logic [1:0] RATIO_RSVD = 2'h3;
  // Delayed CPU reset, two clock periods
  localparam int CPU_RST_DELAY = 2;
  // Width of strap bus
  localparam int STRAP_W = 8;
endpackage

// ### tb/mic_bus_partner.sv
// Pulled-up serial lines of the I2C peripherals and the monitor
`timescale 1ns/10ps
module mic_bus_partner (
  // Block drive, [3] first clock, [2] first data, [1:0] monitor
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  // Peripheral holds a line low
  input wire logic [3:0] hold_low_i,
  // Resolved wire levels
  output logic [3:0] line_o
);
  // Released lines float to the pull-up level
  always_comb
  begin
    line_o = ~((oe_i & ~out_i) | hold_low_i);
  end
endmodule

// ### tb/tb_mic_misc_io.sv
// Self-checking bench for the miscellaneous I/O block
`timescale 1ns/10ps
module tb_mic_misc_io
  import mic_pkg::*;
();
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rd;
    logic [5:0] pins;
    logic [1:0] ratio;
  } mic_row_t;
  logic mclk_i, reset_i, wr_i, rd_i, pci_clk_i;
  logic [7:0] addr_i, wdata_i, rdata_o, strap_i, d;
  logic [3:0] out, oe, hold, line;
  logic gpo, gop, cpu_n, cpu_dn;
  logic [1:0] ratio;
  int n_mismatch, compares;
  mic_row_t rows [17];
  logic [7:0] regs [6];

  mic_misc_io dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .first_serial_clock_line_i(line[3]),
    .first_serial_clock_line_o(out[3]),
    .first_serial_clock_line_oe_o(oe[3]),
    .first_serial_data_line_i(line[2]),
    .first_serial_data_line_o(out[2]),
    .first_serial_data_line_oe_o(oe[2]),
    .monitor_serial_clock_line_i(line[1]),
    .monitor_serial_clock_line_o(out[1]),
    .monitor_serial_clock_line_oe_o(oe[1]),
    .monitor_serial_data_line_i(line[0]),
    .monitor_serial_data_line_o(out[0]),
    .monitor_serial_data_line_oe_o(oe[0]),
    .general_output_pin_o(gpo), .general_output_port_pin_o(gop),
    .pci_clk_i(pci_clk_i), .strap_i(strap_i), .clock_ratio_o(ratio),
    .cpu_reset_n_o(cpu_n), .cpu_reset_delayed_n_o(cpu_dn)
  );

  mic_bus_partner partner (
    .out_i(out), .oe_i(oe), .hold_low_i(hold), .line_o(line)
  );

  // Host clock
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Link clock, free phase against the host clock
  initial
  begin
    pci_clk_i = 1'b0;
    #3;
    forever #62.5 pci_clk_i = ~pci_clk_i;
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
    @(posedge mclk_i);
    #1;
    chk("rd_idle", rdata_o, 8'h00);
  endtask

  // Reset for three cycles, then watch the CPU reset pair
  task automatic rst_seq();
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    chk("cpu_rst_in", {6'h00, cpu_n, cpu_dn}, 8'h00);
    chk("oe_in", {4'h0, oe}, 8'h00);
    @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk("cpu_rst_e1", {6'h00, cpu_n, cpu_dn}, 8'h02);
    @(posedge mclk_i);
    #1;
    chk("cpu_rst_e2", {6'h00, cpu_n, cpu_dn}, 8'h02);
    @(posedge mclk_i);
    #1;
    chk("cpu_rst_e3", {6'h00, cpu_n, cpu_dn}, 8'h03);
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog on the whole run
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    strap_i = 8'hA5;
    hold = 4'h0;
    n_mismatch = 0;
    compares = 0;
    regs = '{ADDR_I2C_CTRL, ADDR_DDC_CTRL, ADDR_SEQ_GPO, ADDR_GOP_CTRL,
      ADDR_OSEL, ADDR_RATIO};
    rows = '{
      '{ADDR_I2C_CTRL, 8'h13, 8'h1F, 6'h3C, 2'h0},
      '{ADDR_I2C_CTRL, 8'h11, 8'h15, 6'h2C, 2'h0},
      '{ADDR_I2C_CTRL, 8'h12, 8'h1A, 6'h1C, 2'h0},
      '{ADDR_DDC_CTRL, 8'h11, 8'h15, 6'h18, 2'h0},
      '{ADDR_DDC_CTRL, 8'h12, 8'h1A, 6'h14, 2'h0},
      '{ADDR_DDC_CTRL, 8'h00, 8'h0C, 6'h1C, 2'h0},
      '{ADDR_I2C_CTRL, 8'h02, 8'h0E, 6'h3C, 2'h0},
      '{ADDR_SEQ_GPO, 8'h01, 8'h01, 6'h3E, 2'h0},
      '{ADDR_GOP_CTRL, 8'h01, 8'h01, 6'h3F, 2'h0},
      '{ADDR_OSEL, 8'h10, 8'h10, 6'h3F, 2'h0},
      '{ADDR_GOP_CTRL, 8'h00, 8'h00, 6'h3F, 2'h0},
      '{ADDR_OSEL, 8'h00, 8'h00, 6'h3E, 2'h0},
      '{ADDR_SEQ_GPO, 8'h00, 8'h00, 6'h3C, 2'h0},
      '{ADDR_RATIO, 8'h01, 8'h01, 6'h3C, 2'h1},
      '{ADDR_RATIO, 8'h02, 8'h02, 6'h3C, 2'h2},
      '{ADDR_RATIO, 8'h03, 8'h02, 6'h3C, 2'h2},
      '{ADDR_RATIO, 8'h00, 8'h00, 6'h3C, 2'h0}};
    rst_seq();
    rd(ADDR_STRAP, d);
    chk("strap", d, 8'hA5);
    $display("Test reset: done");
    // Ordinary register and pin cases
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      repeat (8) @(posedge mclk_i);
      rd(rows[i].addr, d);
      chk("readback", d, rows[i].rd);
      chk("pins", {2'h0, line, gpo, gop}, {2'h0, rows[i].pins});
      chk("ratio", {6'h00, ratio}, {6'h00, rows[i].ratio});
    end
    $display("Test table: done");
    // Disabled port still shows a line held low outside
    hold <= 4'h4;
    repeat (8) @(posedge mclk_i);
    rd(ADDR_I2C_CTRL, d);
    chk("held_low", d, 8'h06);
    hold <= 4'h0;
    // Unmapped place and read-only straps
    wr(8'h20, 8'hFF);
    rd(8'h20, d);
    chk("unmapped", d, 8'h00);
    wr(ADDR_STRAP, 8'h00);
    strap_i <= 8'h5A;
    rd(ADDR_STRAP, d);
    chk("strap_held", d, 8'hA5);
    // Link clock of 125 ns spans 12 or 13 host clocks
    rd(ADDR_PCLK_STAT, d);
    chk("pclk_period", d & 8'hFE, 8'h0C);
    $display("Test odd places: done");
    // Reset in mid-run returns every writable register to default
    foreach (regs[i])
      wr(regs[i], 8'h11);
    rst_seq();
    foreach (regs[i])
    begin
      rd(regs[i], d);
      chk("default", d, (regs[i] < 8'h08) ? 8'h0C : 8'h00);
    end
    rd(ADDR_STRAP, d);
    chk("strap_new", d, 8'h5A);
    $display("Test mid-run reset: done");
    end_sim();
  end
endmodule
